/* src/alarm_map.svh */
// Register offsets, field positions and reset values of the alarm monitor.
`ifndef ALARM_MAP_SVH
`define ALARM_MAP_SVH

`define ADDR_WIDTH 12
`define ADDR_CTRL 12'h000
`define ADDR_STATUS 12'h004
`define ADDR_MASK 12'h008
`define ADDR_SUMMARY 12'h00C
`define ADDR_LANE 12'h010
`define ADDR_LIVE 12'h014

`define CTRL_WIDTH 5
`define CTRL_LINK_EN 0
`define CTRL_PD_A 1
`define CTRL_PD_B 2
`define CTRL_PIN_SEL 3
`define CTRL_GPD_MODE 4
`define CTRL_RESET 5'h00

`define EV_COUNT 6
`define EV_CPLL 0
`define EV_SPLL 1
`define EV_LINK 2
`define EV_SYSREF 3
`define EV_CLOCK 4
`define EV_FIFO 5
`define STATUS_RESET 6'h00
`define MASK_RESET 6'h3F

`define SYNC_WIDTH 3
`define SYNC_CPLL 0
`define SYNC_SPLL 1
`define SYNC_GPD 2
`define SYNC_RESET 3'h3

`endif

/* src/alarm_pkg.sv */
// Types and helper functions shared by the alarm monitor modules.
`default_nettype none
`include "alarm_map.svh"
package alarm_pkg;
   typedef logic [`EV_COUNT-1:0] event_vec_type;
   typedef logic [`ADDR_WIDTH-1:0] addr_type;
   typedef enum {SEL_CTRL, SEL_STATUS, SEL_MASK, SEL_SUMMARY, SEL_LANE, SEL_LIVE, SEL_NONE} reg_sel_type;

   function automatic reg_sel_type decode(input addr_type addr);
      case (addr)
         `ADDR_CTRL: decode = SEL_CTRL;
         `ADDR_STATUS: decode = SEL_STATUS;
         `ADDR_MASK: decode = SEL_MASK;
         `ADDR_SUMMARY: decode = SEL_SUMMARY;
         `ADDR_LANE: decode = SEL_LANE;
         `ADDR_LIVE: decode = SEL_LIVE;
         default: decode = SEL_NONE;
      endcase
   endfunction

   // Sticky update where a new event wins over a clearing one.
   function automatic logic [31:0] sticky_w1c(input logic [31:0] cur, input logic [31:0] set,
                                              input logic [31:0] clr);
      sticky_w1c = (cur & ~clr) | set;
   endfunction
endpackage
`default_nettype wire

/* src/alarm_evt_if.sv */
// Event signals between the alarm monitor and its detectors.
`timescale 1ns/10ps
`default_nettype none
interface alarm_evt_if #(parameter int LANES = 8);
   logic link_active;
   logic compare_active;
   logic clock_upset;
   logic [LANES-1:0] lane_error;
   modport ctrl (output link_active, output compare_active, input clock_upset, input lane_error);
   modport compare (input compare_active, output clock_upset);
   modport fifo (input link_active, output lane_error);
endinterface
`default_nettype wire

/* src/clock_upset_compare.sv */
// Compares the channel A and channel B internal clock states each cycle while compare_active is set.
`timescale 1ns/10ps
`default_nettype none
module clock_upset_compare #(
   parameter int PHASE_W = 4
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [PHASE_W-1:0] chan_a_clk_state,
   input wire logic [PHASE_W-1:0] chan_b_clk_state,
   alarm_evt_if.compare evt
);
   logic upset_q;
   logic upset_d;

   always_comb begin
      upset_d = evt.compare_active & (chan_a_clk_state != chan_b_clk_state);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         upset_q <= 1'b0;
      end else begin
         upset_q <= upset_d;
      end
   end

   assign evt.clock_upset = upset_q;
endmodule // clock_upset_compare
`default_nettype wire

/* src/lane_fifo_monitor.sv */
// Flags read or write errors of each lane's synchronizing FIFO.
`timescale 1ns/10ps
`default_nettype none
module lane_fifo_monitor #(
   parameter int LANES = 8
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [LANES-1:0] lane_rd_error,
   input wire logic [LANES-1:0] lane_wr_error,
   alarm_evt_if.fifo evt
);
   logic [LANES-1:0] err_q;
   logic [LANES-1:0] err_d;

   always_comb begin
      err_d = evt.link_active ? (lane_rd_error | lane_wr_error) : '0;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         err_q <= '0;
      end else begin
         err_q <= err_d;
      end
   end

   assign evt.lane_error = err_q;
endmodule // lane_fifo_monitor
`default_nettype wire

/* src/alarm_monitor_upset_detect.sv */
// Alarm monitor with clock upset and lane FIFO error detection behind APB.
`timescale 1ns/10ps
`default_nettype none
`include "alarm_map.svh"
module alarm_monitor_upset_detect #(
   parameter int LANES = 8,
   parameter int PHASE_W = 4
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire alarm_pkg::addr_type paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic cpll_locked,
   input wire logic spll_locked,
   input wire logic global_powerdown_pin,
   input wire logic link_in_data_state,
   input wire logic sysref_realign,
   input wire logic [PHASE_W-1:0] chan_a_clk_state,
   input wire logic [PHASE_W-1:0] chan_b_clk_state,
   input wire logic [LANES-1:0] lane_rd_error,
   input wire logic [LANES-1:0] lane_wr_error,
   input wire logic cal_status_in,
   output logic calibration_status_pin,
   output logic alarm_irq,
   output logic link_reset_n,
   output logic fifo_reset_n,
   output logic serializer_powerdown,
   output logic link_clk_gate_en,
   output logic chan_a_powerdown,
   output logic chan_b_powerdown,
   output logic global_powerdown
);
   import alarm_pkg::*;

   alarm_evt_if #(.LANES(LANES)) evt ();

   logic [`CTRL_WIDTH-1:0] ctrl_q;
   logic [`CTRL_WIDTH-1:0] ctrl_d;
   event_vec_type event_status_bits_q;
   event_vec_type event_status_bits_d;
   event_vec_type event_mask_bits_q;
   event_vec_type event_mask_bits_d;
   logic [LANES-1:0] lane_fifo_error_flags_q;
   logic [LANES-1:0] lane_fifo_error_flags_d;
   logic [`SYNC_WIDTH-1:0] sync1_q;
   logic [`SYNC_WIDTH-1:0] sync2_q;
   logic [31:0] prdata_q;
   logic [31:0] prdata_d;
   logic alarm_q;
   logic alarm_d;
   logic pin_q;
   logic pin_d;
   logic gpd_q;
   logic gpd_d;

   reg_sel_type sel;
   logic wr_access;
   logic setup_phase;
   event_vec_type event_set;
   event_vec_type status_clr;
   logic [LANES-1:0] lane_clr;
   logic link_en;
   logic cpll_ok;
   logic spll_ok;
   logic gpd_pin;

   // Register bus decode.
   assign sel = decode(paddr);
   assign setup_phase = psel & ~penable;
   assign wr_access = psel & penable & pwrite;
   assign pready = 1'b1;
   assign pslverr = psel & penable & (sel == SEL_NONE);

   // The lock and power-down pins arrive from outside the clock domain.
   always_ff @(posedge pclk or negedge presetn) begin
      // Lock inputs reset to their locked level so release raises no false unlock alarm.
      if (!presetn) begin
         sync1_q <= `SYNC_RESET;
         sync2_q <= `SYNC_RESET;
      end else begin
         sync1_q <= {global_powerdown_pin, spll_locked, cpll_locked};
         sync2_q <= sync1_q;
      end
   end

   assign cpll_ok = sync2_q[`SYNC_CPLL];
   assign spll_ok = sync2_q[`SYNC_SPLL];
   assign gpd_pin = sync2_q[`SYNC_GPD];

   assign link_en = ctrl_q[`CTRL_LINK_EN];

   // Detector enables.
   always_comb begin
      gpd_d = ctrl_q[`CTRL_GPD_MODE] | gpd_pin;
      // FIFO logic runs only while enabled
      evt.link_active = link_en & ~gpd_q;
      evt.compare_active = link_en & ~gpd_q & ~ctrl_q[`CTRL_PD_A] & ~ctrl_q[`CTRL_PD_B];
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gpd_q <= 1'b0;
      end else begin
         gpd_q <= gpd_d;
      end
   end

   clock_upset_compare #(
      .PHASE_W(PHASE_W)
   ) u_compare (
      .pclk(pclk),
      .presetn(presetn),
      .chan_a_clk_state(chan_a_clk_state),
      .chan_b_clk_state(chan_b_clk_state),
      .evt(evt.compare)
   );

   lane_fifo_monitor #(
      .LANES(LANES)
   ) u_fifo (
      .pclk(pclk),
      .presetn(presetn),
      .lane_rd_error(lane_rd_error),
      .lane_wr_error(lane_wr_error),
      .evt(evt.fifo)
   );

   // Event sources.
   always_comb begin
      event_set = '0;
      // PLL unlock, link state, SYSREF realign, clock upset and lane FIFO alarms
      event_set[`EV_CPLL] = ~gpd_q & ~cpll_ok;
      event_set[`EV_SPLL] = ~gpd_q & ~spll_ok;
      event_set[`EV_LINK] = evt.link_active & ~link_in_data_state;
      event_set[`EV_SYSREF] = sysref_realign;
      event_set[`EV_CLOCK] = evt.clock_upset;
      event_set[`EV_FIFO] = |evt.lane_error;
   end

   // Clearing writes, only ones clear.
   always_comb begin
      status_clr = '0;
      lane_clr = '0;
      if (wr_access && sel == SEL_STATUS) begin
         status_clr = pwdata[`EV_COUNT-1:0];
      end
      if (wr_access && sel == SEL_LANE) begin
         lane_clr = pwdata[LANES-1:0];
      end
   end

   // Control and mask registers.
   always_comb begin
      ctrl_d = ctrl_q;
      event_mask_bits_d = event_mask_bits_q;
      if (wr_access && sel == SEL_CTRL) begin
         ctrl_d = pwdata[`CTRL_WIDTH-1:0];
      end
      if (wr_access && sel == SEL_MASK) begin
         event_mask_bits_d = pwdata[`EV_COUNT-1:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= `CTRL_RESET;
         event_mask_bits_q <= `MASK_RESET;
      end else begin
         ctrl_q <= ctrl_d;
         event_mask_bits_q <= event_mask_bits_d;
      end
   end

   // Sticky flags where a new event wins over a clear in the same cycle.
   always_comb begin
      event_status_bits_d = event_vec_type'(sticky_w1c(32'(event_status_bits_q), 32'(event_set),
                                                       32'(status_clr)));
      lane_fifo_error_flags_d = LANES'(sticky_w1c(32'(lane_fifo_error_flags_q),
                                                  32'(evt.lane_error), 32'(lane_clr)));
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         event_status_bits_q <= `STATUS_RESET;
         lane_fifo_error_flags_q <= '0;
      end else begin
         event_status_bits_q <= event_status_bits_d;
         lane_fifo_error_flags_q <= lane_fifo_error_flags_d;
      end
   end

   // Summary alarm and status pin.
   always_comb begin
      alarm_d = |(event_status_bits_q & ~event_mask_bits_q);
      pin_d = ctrl_q[`CTRL_PIN_SEL] ? alarm_d : cal_status_in;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         alarm_q <= 1'b0;
         pin_q <= 1'b0;
      end else begin
         alarm_q <= alarm_d;
         pin_q <= pin_d;
      end
   end

   // Read data is captured in the setup cycle and held through the access.
   always_comb begin
      prdata_d = prdata_q;
      if (setup_phase && !pwrite) begin
         case (sel)
            SEL_CTRL: prdata_d = 32'(ctrl_q);
            SEL_STATUS: prdata_d = 32'(event_status_bits_q);
            SEL_MASK: prdata_d = 32'(event_mask_bits_q);
            SEL_SUMMARY: prdata_d = 32'(alarm_q);
            SEL_LANE: prdata_d = 32'(lane_fifo_error_flags_q);
            SEL_LIVE: prdata_d = 32'({gpd_q, link_in_data_state, spll_ok, cpll_ok});
            default: prdata_d = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= 32'h0000_0000;
      end else begin
         prdata_q <= prdata_d;
      end
   end

   assign prdata = prdata_q;
   assign alarm_irq = alarm_q;
   assign calibration_status_pin = pin_q;
   assign global_powerdown = gpd_q;
   assign chan_a_powerdown = ctrl_q[`CTRL_PD_A];
   assign chan_b_powerdown = ctrl_q[`CTRL_PD_B];

   assign link_reset_n = link_en;
   assign serializer_powerdown = ~link_en;
   assign link_clk_gate_en = link_en;
   assign fifo_reset_n = link_en;
endmodule // alarm_monitor_upset_detect
`default_nettype wire

/* verif/alarm_monitor_upset_detect_monitor.sv */
// Concurrent checks on the alarm monitor ports.
`timescale 1ns/10ps
`default_nettype none
module alarm_monitor_upset_detect_monitor (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire alarm_pkg::addr_type paddr,
   input wire logic [31:0] pwdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic alarm_irq,
   input wire logic cal_status_in,
   input wire logic calibration_status_pin,
   input wire logic link_reset_n,
   input wire logic fifo_reset_n,
   input wire logic serializer_powerdown,
   input wire logic link_clk_gate_en
);
   import alarm_pkg::*;
   logic acc;
   logic wr;
   logic sel_q;
   logic sel_d;
   assign acc = psel && penable && pready;
   assign wr = acc && pwrite && (paddr == 12'h004 || paddr == 12'h008 || paddr == 12'h010);
   // Shadow of the pin select bit, so pin checks know the routing.
   always_comb begin
      sel_d = sel_q;
      if (acc && pwrite && paddr == 12'h000) begin
         sel_d = pwdata[3];
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sel_q <= 1'b0;
      end else begin
         sel_q <= sel_d;
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   link_follow_a: assert property (acc && pwrite && paddr == 12'h000 |=> link_clk_gate_en == $past(pwdata[0]))
      else $error("link enable output wrong");
   fifo_reset_a: assert property (fifo_reset_n == link_clk_gate_en) else $error("fifo reset wrong");
   ser_down_a: assert property (serializer_powerdown != link_clk_gate_en && link_reset_n == link_clk_gate_en)
      else $error("link section state wrong");
   irq_sticky_a: assert property ($fell(alarm_irq) |-> $past(wr) || $past(wr, 2) || $past(wr, 3))
      else $error("alarm dropped without host write");
   mask_all_a: assert property (acc && pwrite && paddr == 12'h008 && pwdata[5:0] == 6'h3F |-> ##[1:2] !alarm_irq)
      else $error("masked alarm still raised");
   pin_alarm_a: assert property (sel_q && $past(sel_q) && alarm_irq && $past(alarm_irq) |-> calibration_status_pin)
      else $error("pin not showing alarm");
   pin_pass_a: assert property (!sel_q && !$past(sel_q) |-> calibration_status_pin == $past(cal_status_in))
      else $error("pin not passing status");
   bad_addr_a: assert property (acc && (paddr > 12'h014 || paddr[1:0] != 2'b00) |-> pslverr)
      else $error("no error on unmapped address");
   good_addr_a: assert property (acc && paddr <= 12'h014 && paddr[1:0] == 2'b00 |-> !pslverr)
      else $error("error on mapped address");
   cover property (acc && pslverr);
   cover property ($rose(alarm_irq));
   cover property (sel_q && $rose(calibration_status_pin));
endmodule // alarm_monitor_upset_detect_monitor
`default_nettype wire

/* verif/alarm_monitor_upset_detect_tb.sv */
// Self-checking bench for the alarm monitor.
`timescale 1ns/10ps
`default_nettype none
module alarm_monitor_upset_detect_tb;
   import alarm_pkg::*;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   addr_type paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic cpll_locked = 1'b1;
   logic spll_locked = 1'b1;
   logic gpd_pin = 1'b0;
   logic link_in_data_state = 1'b1;
   logic sysref_realign = 1'b0;
   logic cal_status_in = 1'b0;
   logic [3:0] chan_a_clk_state = 4'h0;
   logic [3:0] chan_b_clk_state = 4'h0;
   logic [7:0] lane_rd_error = 8'h00;
   logic [7:0] lane_wr_error = 8'h00;
   logic [31:0] prdata;
   logic [31:0] rd;
   logic pready, pslverr, pin, alarm_irq, err;
   logic link_reset_n, fifo_reset_n, serializer_powerdown, link_clk_gate_en, pd_a, pd_b, gpd;
   int bad_count = 0;
   int check_count = 0;
   int cyc = 0;
   alarm_monitor_upset_detect dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .cpll_locked(cpll_locked), .spll_locked(spll_locked), .global_powerdown_pin(gpd_pin),
      .link_in_data_state(link_in_data_state), .sysref_realign(sysref_realign),
      .chan_a_clk_state(chan_a_clk_state), .chan_b_clk_state(chan_b_clk_state), .lane_rd_error(lane_rd_error),
      .lane_wr_error(lane_wr_error), .cal_status_in(cal_status_in), .calibration_status_pin(pin),
      .alarm_irq(alarm_irq), .link_reset_n(link_reset_n), .fifo_reset_n(fifo_reset_n),
      .serializer_powerdown(serializer_powerdown), .link_clk_gate_en(link_clk_gate_en),
      .chan_a_powerdown(pd_a), .chan_b_powerdown(pd_b), .global_powerdown(gpd));
   always #4 pclk = ~pclk;
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         bad_count = bad_count + 1;
         end_sim();
      end
   end
   task automatic end_sim();
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      check_count++;
      if (s !== e) begin
         bad_count++;
         $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge pclk);
   endtask
   task automatic bus(input logic w, input addr_type a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic rchk(input addr_type a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(rd, e);
   endtask
   // Raises one event source for a single clock cycle.
   task automatic pulse(input int i);
      for (int k = 1; k >= 0; k--) begin
         case (i)
            0: cpll_locked <= k[0] ? 1'b0 : 1'b1;
            1: spll_locked <= k[0] ? 1'b0 : 1'b1;
            2: link_in_data_state <= k[0] ? 1'b0 : 1'b1;
            3: sysref_realign <= k[0];
            4: chan_b_clk_state <= k[0] ? 4'h1 : 4'h0;
            default: lane_rd_error <= k[0] ? 8'h01 : 8'h00;
         endcase
         tick(k == 1 ? 1 : 4);
      end
   endtask
   task automatic t_reset();
      rchk(12'h004, 32'h0);
      rchk(12'h000, 32'h0);
      rchk(12'h008, 32'h3F);
      rchk(12'h010, 32'h0);
      bus(1'b1, 12'h004, 32'h3F);
      rchk(12'h004, 32'h0);
      bus(1'b0, 12'h018, 32'h0);
      chk({31'h0, err}, 32'h1);
      chk(rd, 32'h0);
      bus(1'b0, 12'h002, 32'h0);
      chk({31'h0, err}, 32'h1);
      $display("reset test done");
   endtask
   task automatic t_events();
      bus(1'b1, 12'h000, 32'h0);
      bus(1'b1, 12'h000, 32'h1);
      bus(1'b1, 12'h004, 32'h10);
      bus(1'b1, 12'h008, 32'h0);
      for (int i = 0; i < 6; i++) begin
         pulse(i);
         rchk(12'h004, 32'h1 << i);
         chk({31'h0, alarm_irq}, 32'h1);
         bus(1'b1, 12'h004, 32'h0);
         rchk(12'h004, 32'h1 << i);
         bus(1'b1, 12'h010, 32'hFF);
         bus(1'b1, 12'h004, 32'h1 << i);
         rchk(12'h004, 32'h0);
         chk({31'h0, alarm_irq}, 32'h0);
      end
      $display("events test done");
   endtask
   task automatic t_mask();
      bus(1'b1, 12'h008, 32'h3F);
      pulse(3);
      rchk(12'h004, 32'h08);
      chk({31'h0, alarm_irq}, 32'h0);
      bus(1'b1, 12'h008, 32'h37);
      tick(2);
      chk({31'h0, alarm_irq}, 32'h1);
      rchk(12'h00C, 32'h1);
      bus(1'b1, 12'h004, 32'h08);
      $display("mask test done");
   endtask
   task automatic t_pin();
      cal_status_in <= 1'b1;
      tick(3);
      chk({31'h0, pin}, 32'h1);
      bus(1'b1, 12'h000, 32'h9);
      tick(2);
      chk({31'h0, pin}, 32'h0);
      pulse(3);
      chk({31'h0, pin}, 32'h1);
      bus(1'b1, 12'h004, 32'h08);
      tick(2);
      chk({31'h0, pin}, 32'h0);
      $display("pin test done");
   endtask
   task automatic t_fifo();
      lane_wr_error <= 8'h80;
      tick(1);
      lane_wr_error <= 8'h00;
      tick(4);
      rchk(12'h010, 32'h80);
      bus(1'b1, 12'h000, 32'h6);
      chk({29'h0, fifo_reset_n, serializer_powerdown, link_clk_gate_en}, 32'h2);
      chk({30'h0, pd_b, pd_a}, 32'h3);
      lane_wr_error <= 8'h01;
      tick(1);
      lane_wr_error <= 8'h00;
      tick(4);
      bus(1'b1, 12'h000, 32'h1);
      chk({29'h0, fifo_reset_n, serializer_powerdown, link_clk_gate_en}, 32'h5);
      rchk(12'h010, 32'h80);
      bus(1'b1, 12'h010, 32'h80);
      rchk(12'h010, 32'h0);
      $display("fifo test done");
   endtask
   task automatic t_gpd();
      gpd_pin <= 1'b1;
      tick(4);
      chk({31'h0, gpd}, 32'h1);
      rchk(12'h014, 32'hF);
      gpd_pin <= 1'b0;
      tick(4);
      bus(1'b1, 12'h000, 32'h11);
      rchk(12'h014, 32'hF);
      bus(1'b1, 12'h000, 32'h1);
      bus(1'b1, 12'h004, 32'h10);
      rchk(12'h004, 32'h20);
      rchk(12'h014, 32'h7);
      chk({31'h0, gpd}, 32'h0);
      $display("power-down test done");
   endtask
   initial begin
      tick(16);
      presetn <= 1'b1;
      tick(1);
      t_reset();
      t_events();
      t_mask();
      t_pin();
      t_fifo();
      t_gpd();
      end_sim();
   end
endmodule // alarm_monitor_upset_detect_tb
bind alarm_monitor_upset_detect alarm_monitor_upset_detect_monitor mon (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
   .pslverr(pslverr), .alarm_irq(alarm_irq), .cal_status_in(cal_status_in),
   .calibration_status_pin(calibration_status_pin), .link_reset_n(link_reset_n), .fifo_reset_n(fifo_reset_n),
   .serializer_powerdown(serializer_powerdown), .link_clk_gate_en(link_clk_gate_en));
`default_nettype wire
